// ### led_mode3_indicator.v
// Mode-3 LED indication logic with AHB-Lite control registers
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "led_mode3_map.vh"
module led_mode3_indicator
#(
    parameter PORTS = 8,
    parameter RX_CYCLES = `RX_STRETCH_CYCLES,
    parameter COL_CYCLES = `COL_STRETCH_CYCLES,
    parameter ACT_CYCLES = `ACT_STRETCH_CYCLES,
    parameter FLASH_CYCLES = `FLASH_HALF_CYCLES
)
(
    input wire CLOCK,
    input wire RSTN,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire HREADY,
    input wire [31:0] HWDATA,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire [PORTS-1:0] LINK_GOOD,
    input wire [PORTS-1:0] PARTITIONED,
    input wire [PORTS-1:0] SPEED_100,
    input wire [PORTS-1:0] SELECT_100,
    input wire [PORTS-1:0] RX_EVENT,
    input wire COLLISION_EVENT,
    input wire ACTIVITY_EVENT,
    input wire BACKUP_SUPPLY_PRESENT,
    input wire BACKUP_SUPPLY_FAULT,
    input wire MANAGER_PRESENT,
    output reg [PORTS-1:0] PORT_LINK_LAMP,
    output reg [PORTS-1:0] PORT_RX_LAMP,
    output reg [PORTS-1:0] PORT_SPEED_LAMP,
    output reg COLLISION_LAMP,
    output reg ACTIVITY_LAMP,
    output reg FAULT_LAMP,
    output reg MANAGER_LAMP
);
    // ----------------------------------------
    // Input synchronisers, three stages
    // ----------------------------------------
    localparam NIN = 5 * PORTS + 5;
    wire [NIN-1:0] raw_in = {LINK_GOOD, PARTITIONED, SPEED_100, SELECT_100, RX_EVENT,
        COLLISION_EVENT, ACTIVITY_EVENT, BACKUP_SUPPLY_PRESENT, BACKUP_SUPPLY_FAULT, MANAGER_PRESENT};
    reg [NIN-1:0] sync1;
    reg [NIN-1:0] sync2;
    reg [NIN-1:0] sync3;
    reg [NIN-1:0] stable;
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sync1 <= {NIN{1'b0}};
            sync2 <= {NIN{1'b0}};
            sync3 <= {NIN{1'b0}};
            stable <= {NIN{1'b0}};
        end
        else
        begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            // A bit changes only once stages two and three agree
            stable <= (sync2 & sync3) | (stable & (sync2 | sync3));
        end
    end
    wire [PORTS-1:0] link_good = stable[5*PORTS+4:4*PORTS+5];
    wire [PORTS-1:0] partitioned = stable[4*PORTS+4:3*PORTS+5];
    wire [PORTS-1:0] speed_100 = stable[3*PORTS+4:2*PORTS+5];
    wire [PORTS-1:0] select_100 = stable[2*PORTS+4:PORTS+5];
    wire [PORTS-1:0] rx_event = stable[PORTS+4:5];
    wire collision_event = stable[4];
    wire activity_event = stable[3];
    wire backup_supply_present = stable[2];
    wire backup_supply_fault = stable[1];
    wire manager_present = stable[0];

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    reg [31:0] port_off;
    reg [31:0] global_ctrl;
    reg [31:0] port_mode;
    reg wr_pending;
    reg [7:0] wr_addr;
    wire take = HSEL & HREADY & HTRANS[1];
    wire [31:0] status_word = {{(32-PORTS){1'b0}}, partitioned};
    wire [31:0] lamp_word = {{(32-3*PORTS-4){1'b0}}, MANAGER_LAMP, FAULT_LAMP, ACTIVITY_LAMP,
        COLLISION_LAMP, PORT_SPEED_LAMP, PORT_RX_LAMP, PORT_LINK_LAMP};
    reg [31:0] next_rdata;
    always @*
    begin
        case (HADDR[7:0])
            `ADDR_PORT_OFF: next_rdata = port_off;
            `ADDR_GLOBAL_CTRL: next_rdata = global_ctrl;
            `ADDR_PORT_MODE: next_rdata = port_mode;
            `ADDR_STATUS: next_rdata = status_word;
            `ADDR_LAMPS: next_rdata = lamp_word;
            default: next_rdata = 32'h00000000;
        endcase
    end
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            port_off <= `PORT_OFF_RESET;
            global_ctrl <= `GLOBAL_CTRL_RESET;
            port_mode <= `PORT_MODE_RESET;
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            if (wr_pending)
            begin
                case (wr_addr)
                    `ADDR_PORT_OFF: port_off <= HWDATA;
                    `ADDR_GLOBAL_CTRL: global_ctrl <= HWDATA;
                    `ADDR_PORT_MODE: port_mode <= HWDATA;
                    default: ;
                endcase
            end
            wr_pending <= take & HWRITE;
            wr_addr <= HADDR[7:0];
            if (take & ~HWRITE)
                HRDATA <= next_rdata;
        end
    end

    // ----------------------------------------
    // Stretchers and flash timer
    // ----------------------------------------
    wire [PORTS-1:0] rx_stretched;
    wire col_stretched;
    wire act_stretched;
    genvar i;
    generate
        for (i = 0; i < PORTS; i = i + 1)
        begin : rx_gen
            pulse_stretch #(.LENGTH(RX_CYCLES)) rx_str (.clk(CLOCK), .rst_n(RSTN),
                .trigger(rx_event[i]), .lamp(rx_stretched[i]));
        end
    endgenerate
    pulse_stretch #(.LENGTH(COL_CYCLES)) col_str (.clk(CLOCK), .rst_n(RSTN),
        .trigger(collision_event), .lamp(col_stretched));
    pulse_stretch #(.LENGTH(ACT_CYCLES)) act_str (.clk(CLOCK), .rst_n(RSTN),
        .trigger(activity_event), .lamp(act_stretched));
    reg [31:0] flash_count;
    reg flash;
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            flash_count <= 32'h00000000;
            flash <= 1'b0;
        end
        else if (flash_count == FLASH_CYCLES - 1)
        begin
            flash_count <= 32'h00000000;
            flash <= ~flash;
        end
        else
            flash_count <= flash_count + 32'h00000001;
    end

    // ----------------------------------------
    // Lamp decode
    // ----------------------------------------
    wire autoneg = port_mode[`MODE_AUTONEG_BIT];
    wire auto_flash_option = port_mode[`MODE_FLASH_BIT];
    wire [PORTS-1:0] force_off = port_off[PORTS-1:0];
    wire [PORTS-1:0] next_link = link_good & ~partitioned & ~force_off;
    wire [PORTS-1:0] next_speed = (autoneg & auto_flash_option) ?
        ((link_good & speed_100) | (~link_good & {PORTS{flash}})) & ~force_off
        : select_100 & ~force_off;
    wire next_fault = ((|partitioned) | (backup_supply_present & backup_supply_fault))
        & ~global_ctrl[`GLB_FAULT_OFF_BIT];
    always @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PORT_LINK_LAMP <= {PORTS{1'b0}};
            PORT_RX_LAMP <= {PORTS{1'b0}};
            PORT_SPEED_LAMP <= {PORTS{1'b0}};
            COLLISION_LAMP <= 1'b0;
            ACTIVITY_LAMP <= 1'b0;
            FAULT_LAMP <= 1'b0;
            MANAGER_LAMP <= 1'b0;
        end
        else
        begin
            PORT_LINK_LAMP <= next_link;
            PORT_RX_LAMP <= rx_stretched;
            PORT_SPEED_LAMP <= next_speed;
            COLLISION_LAMP <= col_stretched;
            ACTIVITY_LAMP <= act_stretched;
            FAULT_LAMP <= next_fault;
            MANAGER_LAMP <= manager_present;
        end
    end
endmodule
`default_nettype wire

// ### led_mode3_map.vh
// Register map, field positions, reset values and timing constants of the LED indicator
`ifndef LED_MODE3_MAP_VH
`define LED_MODE3_MAP_VH
`define CLOCK_HZ 25000000
`define RX_STRETCH_MS 20
`define RX_STRETCH_CYCLES ((`CLOCK_HZ / 1000) * `RX_STRETCH_MS)
`define COL_STRETCH_CYCLES 3000
`define ACT_STRETCH_CYCLES 100000
`define FLASH_HALF_CYCLES 1250000
`define ADDR_PORT_OFF 8'h00
`define ADDR_GLOBAL_CTRL 8'h04
`define ADDR_PORT_MODE 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_LAMPS 8'h10
`define GLB_FAULT_OFF_BIT 0
`define MODE_AUTONEG_BIT 0
`define MODE_FLASH_BIT 1
`define PORT_OFF_RESET 32'h00000000
`define GLOBAL_CTRL_RESET 32'h00000000
`define PORT_MODE_RESET 32'h00000003
`endif

// ### pulse_stretch.v
// Pulse stretcher: fixed on-time, then an equal forced off-time
`timescale 1ns/10ps
`default_nettype none
module pulse_stretch
#(
    parameter LENGTH = 500000
)
(
    input wire clk,
    input wire rst_n,
    input wire trigger,
    output reg lamp
);
    localparam IDLE = 2'b00;
    localparam ON = 2'b01;
    localparam OFF = 2'b10;
    reg [1:0] state;
    reg [31:0] count;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= IDLE;
            count <= 32'h00000000;
            lamp <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    if (trigger)
                    begin
                        state <= ON;
                        lamp <= 1'b1;
                        count <= LENGTH - 1;
                    end
                end
                ON:
                begin
                    if (count == 32'h00000000)
                    begin
                        // Off-time equals on-time, new events are ignored meanwhile
                        state <= OFF;
                        lamp <= 1'b0;
                        count <= LENGTH - 1;
                    end
                    else
                        count <= count - 32'h00000001;
                end
                OFF:
                begin
                    if (count == 32'h00000000)
                    begin
                        // Restart at once so the forced off-time is exactly LENGTH cycles
                        if (trigger)
                        begin
                            state <= ON;
                            lamp <= 1'b1;
                            count <= LENGTH - 1;
                        end
                        else
                            state <= IDLE;
                    end
                    else
                        count <= count - 32'h00000001;
                end
                default:
                begin
                    state <= IDLE;
                    lamp <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### led_mode3_indicator_assertions.sv
// Concurrent checks on the ports of the LED indicator
`timescale 1ns/10ps
`default_nettype none
module led_mode3_checker
#(
    parameter PORTS = 8,
    parameter COL_CYCLES = 3000,
    parameter ACT_CYCLES = 100000
)
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [PORTS-1:0] LINK_GOOD,
    input wire logic [PORTS-1:0] PARTITIONED,
    input wire logic BACKUP_SUPPLY_PRESENT,
    input wire logic BACKUP_SUPPLY_FAULT,
    input wire logic MANAGER_PRESENT,
    input wire logic [PORTS-1:0] PORT_LINK_LAMP,
    input wire logic COLLISION_LAMP,
    input wire logic ACTIVITY_LAMP,
    input wire logic FAULT_LAMP,
    input wire logic MANAGER_LAMP
);
// ----
// Run lengths of the stretched lamps
// ----
int col_on;
int col_off;
int act_on;
int act_off;
always @(posedge CLOCK or negedge RSTN)
    if (!RSTN)
    begin
        col_on <= 0;
        col_off <= COL_CYCLES;
        act_on <= 0;
        act_off <= ACT_CYCLES;
    end
    else
    begin
        col_on <= COLLISION_LAMP ? col_on + 1 : 0;
        col_off <= COLLISION_LAMP ? 0 : col_off + 1;
        act_on <= ACTIVITY_LAMP ? act_on + 1 : 0;
        act_off <= ACTIVITY_LAMP ? 0 : act_off + 1;
    end
// Eight steady samples cover the input synchroniser latency
default clocking dc @(posedge CLOCK); endclocking
default disable iff (!RSTN);
sequence s_mgr_up; MANAGER_PRESENT [*8]; endsequence
sequence s_link_bad; (!LINK_GOOD[0] || PARTITIONED[0]) [*8]; endsequence
property p_bus_okay; HREADYOUT && !HRESP; endproperty
property p_link_dark; s_link_bad |-> !PORT_LINK_LAMP[0]; endproperty
property p_col_on; $fell(COLLISION_LAMP) |-> col_on == COL_CYCLES; endproperty
property p_col_off; $rose(COLLISION_LAMP) |-> col_off >= COL_CYCLES; endproperty
property p_act_on; $fell(ACTIVITY_LAMP) |-> act_on == ACT_CYCLES; endproperty
property p_act_off; $rose(ACTIVITY_LAMP) |-> act_off >= ACT_CYCLES; endproperty
property p_fault_dark; (!(|PARTITIONED) && !(BACKUP_SUPPLY_PRESENT && BACKUP_SUPPLY_FAULT)) [*8] |-> !FAULT_LAMP;
endproperty
property p_mgr_on; s_mgr_up |-> MANAGER_LAMP; endproperty
property p_mgr_off; (!MANAGER_PRESENT) [*8] |-> !MANAGER_LAMP; endproperty
a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
a_link_dark: assert property (p_link_dark) else $error("link lamp lit");
a_col_on: assert property (p_col_on) else $error("collision on time");
a_col_off: assert property (p_col_off) else $error("collision off time");
a_act_on: assert property (p_act_on) else $error("activity on time");
a_act_off: assert property (p_act_off) else $error("activity off time");
a_fault_dark: assert property (p_fault_dark) else $error("fault lamp lit");
a_mgr_on: assert property (p_mgr_on) else $error("manager lamp dark");
a_mgr_off: assert property (p_mgr_off) else $error("manager lamp lit");
endmodule
bind led_mode3_indicator led_mode3_checker #(.PORTS(PORTS), .COL_CYCLES(COL_CYCLES), .ACT_CYCLES(ACT_CYCLES)) u_chk (.*);
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the LED indicator
`timescale 1ns/10ps
`default_nettype none
`include "led_mode3_map.vh"
module testbench;
localparam P = 2;
logic CLOCK = 0, RSTN = 0, HSEL = 0, HWRITE = 0;
logic [31:0] HADDR = 0, HWDATA = 0, rd, r, port_off, mode;
logic [1:0] HTRANS = 0;
logic [2:0] HSIZE = 3'h2;
logic [P-1:0] LINK_GOOD = 0, PARTITIONED = 0, SPEED_100 = 0, SELECT_100 = 0, RX_EVENT = 0;
logic COLLISION_EVENT = 0, ACTIVITY_EVENT = 0, BACKUP_SUPPLY_PRESENT = 0, BACKUP_SUPPLY_FAULT = 0, MANAGER_PRESENT = 0;
wire HREADY, HREADYOUT, HRESP, COLLISION_LAMP, ACTIVITY_LAMP, FAULT_LAMP, MANAGER_LAMP;
wire [31:0] HRDATA;
wire [P-1:0] PORT_LINK_LAMP, PORT_RX_LAMP, PORT_SPEED_LAMP;
int n_mismatch = 0, total_checks = 0, cycles = 0, i, k, on, rises;
logic [31:0] seed = 32'h0000E3FA;
logic glb, lamp, prev, seen0, seen1;
assign HREADY = HREADYOUT;
led_mode3_indicator #(.PORTS(P), .RX_CYCLES(20), .COL_CYCLES(8), .ACT_CYCLES(12), .FLASH_CYCLES(4)) u_dut (.*);
initial forever #20 CLOCK = ~CLOCK;
// ----
// Shared tasks
// ----
function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask
task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
endtask
// Model of the steady lamps; a flashing lamp must show both levels
task check_lamps;
    for (k = 0; k < P; k++)
    begin
        compare("link", LINK_GOOD[k] & ~PARTITIONED[k] & ~port_off[k], PORT_LINK_LAMP[k]);
        if (mode[1:0] != 2'h3)
            compare("speed", SELECT_100[k] & ~port_off[k], PORT_SPEED_LAMP[k]);
        else if (LINK_GOOD[k])
            compare("speed", SPEED_100[k] & ~port_off[k], PORT_SPEED_LAMP[k]);
        else if (!port_off[k])
        begin
            seen0 = 0;
            seen1 = 0;
            repeat (10) @(posedge CLOCK) {seen1, seen0} |= {PORT_SPEED_LAMP[k], !PORT_SPEED_LAMP[k]};
            compare("flash", 2'h3, {seen1, seen0});
        end
        else
            compare("speed off", 32'h00000000, PORT_SPEED_LAMP[k]);
    end
    compare("fault", (|PARTITIONED | (BACKUP_SUPPLY_PRESENT & BACKUP_SUPPLY_FAULT)) & ~glb, FAULT_LAMP);
    compare("manager", MANAGER_PRESENT, MANAGER_LAMP);
endtask
// Events keep arriving through the on time and into the off time, then one late burst
task stretch(input int len, input int which);
    on = 0;
    rises = 0;
    prev = 0;
    for (k = 0; k < 4 * len + 20; k++)
    begin
        @(posedge CLOCK);
        lamp = which == 0 ? COLLISION_LAMP : which == 1 ? ACTIVITY_LAMP : PORT_RX_LAMP[0];
        on += lamp;
        rises += lamp & !prev;
        prev = lamp;
        r[0] = k % 6 < 3 && (k < len + len / 2 || (k >= 3 * len && k < 3 * len + 3));
        if (which == 0) COLLISION_EVENT <= r[0];
        else if (which == 1) ACTIVITY_EVENT <= r[0];
        else RX_EVENT <= {1'b0, r[0]};
    end
    compare("on time", 2 * len, on);
    compare("pulses", 2, rises);
    $display("test stretch %0d done", which);
endtask
always @(posedge CLOCK)
begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
        n_mismatch++;
        give_verdict();
    end
end
// ----
// Main sequence
// ----
initial
begin
    repeat (10) @(posedge CLOCK);
    RSTN <= 1'b1;
    bus(0, `ADDR_PORT_MODE, 0);
    compare("mode reset", `PORT_MODE_RESET, rd);
    bus(0, `ADDR_PORT_OFF, 0);
    compare("port off reset", `PORT_OFF_RESET, rd);
    bus(0, `ADDR_GLOBAL_CTRL, 0);
    compare("global reset", `GLOBAL_CTRL_RESET, rd);
    bus(1, 32'h00000040, 32'hFFFFFFFF);
    bus(0, 32'h00000040, 0);
    compare("unmapped", 0, rd);
    $display("test registers done");
    for (i = 0; i < 40; i++)
    begin
        r = rnd();
        {LINK_GOOD, PARTITIONED, SPEED_100, SELECT_100, BACKUP_SUPPLY_PRESENT, BACKUP_SUPPLY_FAULT, MANAGER_PRESENT} <= r[10:0];
        port_off = {30'h0, r[12:11]};
        mode = {30'h0, r[14:13]};
        glb = r[15];
        bus(1, `ADDR_PORT_OFF, port_off);
        bus(1, `ADDR_GLOBAL_CTRL, {31'h0, glb});
        bus(1, `ADDR_PORT_MODE, mode);
        repeat (10) @(posedge CLOCK);
        check_lamps();
        bus(0, `ADDR_STATUS, 0);
        compare("status", {30'h0, PARTITIONED}, rd);
        bus(0, `ADDR_LAMPS, 0);
        compare("lamp word", {22'h0, MANAGER_PRESENT, (|PARTITIONED | (BACKUP_SUPPLY_PRESENT & BACKUP_SUPPLY_FAULT)) & ~glb,
            6'h00, LINK_GOOD & ~PARTITIONED & ~port_off[P-1:0]}, rd & 32'h000003CF);
    end
    $display("test random lamps done");
    bus(1, `ADDR_PORT_OFF, 32'h00000003);
    stretch(8, 0);
    stretch(12, 1);
    stretch(20, 2);
    give_verdict();
end
endmodule
`default_nettype wire
